// File: chgsp_top.sv
module chgsp_top #(
    parameter longint unsigned TIMEOUT_CYCLES = chgsp_pkg::TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic host_addr_valid,
    input wire logic [7:0] host_addr,
    input wire logic host_wr_valid,
    input wire logic [7:0] host_wr_byte,
    input wire logic host_stop,
    input wire logic host_rd_req,
    output logic host_rd_valid,
    output logic [7:0] host_rd_data,
    input wire logic batt_low,
    input wire logic batt_recovered,
    output chgsp_pkg::chgsp_dac_t dac,
    output logic charge_enable,
    output logic foldback_active,
    output logic timed_out
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    logic [7:0] reg_addr;
    logic [1:0] byte_cnt;
    logic [7:0] low_byte;
    logic commit;
    logic commit_cur;
    logic commit_volt;

    assign commit = host_stop && (byte_cnt == 2'h2);
    assign commit_cur = commit && (reg_addr == chgsp_pkg::ADDR_CURRENT);
    assign commit_volt = commit && (reg_addr == chgsp_pkg::ADDR_VOLTAGE);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_addr <= 8'h00;
        else if (host_addr_valid)
            reg_addr <= host_addr;
    end

    // A third data byte spoils the transfer; one register per write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            byte_cnt <= 2'h0;
        else if (host_addr_valid || host_stop)
            byte_cnt <= 2'h0;
        else if (host_wr_valid && byte_cnt != 2'h3)
            byte_cnt <= byte_cnt + 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            low_byte <= 8'h00;
        else if (host_wr_valid && byte_cnt == 2'h0)
            low_byte <= host_wr_byte;
    end

    // High byte is held until the stop closes the transfer
    logic [7:0] high_byte;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            high_byte <= 8'h00;
        else if (host_wr_valid && byte_cnt == 2'h1)
            high_byte <= host_wr_byte;
    end

    logic [15:0] word_in;
    assign word_in = {high_byte, low_byte};

    // ------------------------------------------------------------
    // Set-point registers
    // ------------------------------------------------------------
    logic [15:0] target_cell_flow;
    logic [15:0] target_cell_potential;
    logic cur_written;
    logic volt_written;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            target_cell_flow <= chgsp_pkg::RESET_CURRENT;
        else if (commit_cur)
            target_cell_flow <= word_in;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            target_cell_potential <= chgsp_pkg::RESET_VOLTAGE;
        else if (commit_volt)
            target_cell_potential <= word_in;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_written <= 1'b0;
            volt_written <= 1'b0;
        end
        else
        begin
            if (commit_cur)
                cur_written <= 1'b1;
            if (commit_volt)
                volt_written <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    logic rd_high;
    logic [15:0] rd_word;

    always_comb
    begin
        unique case (reg_addr)
            chgsp_pkg::ADDR_CURRENT: rd_word = target_cell_flow;
            chgsp_pkg::ADDR_VOLTAGE: rd_word = target_cell_potential;
            default: rd_word = {chgsp_pkg::UNMAPPED_READ, chgsp_pkg::UNMAPPED_READ};
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_high <= 1'b0;
        else if (host_addr_valid || host_stop)
            rd_high <= 1'b0;
        else if (host_rd_req)
            rd_high <= !rd_high;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_rd_valid <= 1'b0;
            host_rd_data <= 8'h00;
        end
        else
        begin
            host_rd_valid <= host_rd_req;
            if (host_rd_req)
                host_rd_data <= rd_high ? rd_word[15:8] : rd_word[7:0];
        end
    end

    // ------------------------------------------------------------
    // Low-battery foldback
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            foldback_active <= 1'b0;
        else if (batt_low)
            foldback_active <= 1'b1;
        else if (batt_recovered)
            foldback_active <= 1'b0;
    end

    // ------------------------------------------------------------
    // Write watchdog
    // ------------------------------------------------------------
    logic [35:0] idle_cnt;
    logic [35:0] idle_last;

    assign idle_last = 36'(TIMEOUT_CYCLES - 64'd1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            idle_cnt <= 36'h0;
        else if (commit_cur || commit_volt)
            idle_cnt <= 36'h0;
        else if (!timed_out)
            idle_cnt <= idle_cnt + 36'h1;
    end

    // A write in the expiry cycle wins and keeps charging alive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            timed_out <= 1'b0;
        else if (commit_cur || commit_volt)
            timed_out <= 1'b0;
        else if (idle_cnt == idle_last)
            timed_out <= 1'b1;
    end

    // ------------------------------------------------------------
    // Decode and enable
    // ------------------------------------------------------------
    logic [10:0] next_volt_code;
    logic [5:0] next_curr_code;
    logic next_enable;

    chgsp_volt_decode u_volt (
        .target_cell_potential(target_cell_potential),
        .voltage_dac_bits(next_volt_code)
    );

    chgsp_curr_decode u_curr (
        .target_cell_flow(target_cell_flow),
        .foldback(foldback_active),
        .current_dac_bits(next_curr_code)
    );

    assign next_enable = cur_written && volt_written && !timed_out
        && (target_cell_flow > chgsp_pkg::CURR_EN_MIN)
        && (target_cell_potential > chgsp_pkg::VOLT_EN_MIN)
        && (next_volt_code != 11'h000);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dac <= '0;
            charge_enable <= 1'b0;
        end
        else
        begin
            dac.voltage_dac_bits <= next_volt_code;
            dac.current_dac_bits <= next_curr_code;
            charge_enable <= next_enable;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_addr_cur;
        host_addr_valid && host_addr == chgsp_pkg::ADDR_CURRENT;
    endsequence

    sequence s_two_bytes;
        host_wr_valid ##1 host_wr_valid ##1 host_stop;
    endsequence

    sequence s_read_low;
        host_rd_req && !rd_high;
    endsequence

    a_cur_write_commit: assert property (s_addr_cur ##1 s_two_bytes |=> ##1
        target_cell_flow == {$past(host_wr_byte, 3), $past(host_wr_byte, 4)})
        else $error("current word not stored from two bytes");

    a_read_low_echo: assert property (s_read_low |=> host_rd_valid
        && host_rd_data == $past(rd_word[7:0]))
        else $error("read low byte mismatch");

    a_volt_ceiling: assert property (dac.voltage_dac_bits <= chgsp_pkg::VOLT_CODE_MAX)
        else $error("voltage code above ceiling");

    a_volt_floor: assert property (
        target_cell_potential[chgsp_pkg::VOLT_MSB_POS:chgsp_pkg::VOLT_LSB_POS]
        < chgsp_pkg::VOLT_CODE_MIN
        && !commit_volt |=> dac.voltage_dac_bits == 11'h000 && !charge_enable)
        else $error("low voltage request not zeroed");

    a_fold_force: assert property ($rose(foldback_active) |=>
        dac.current_dac_bits == chgsp_pkg::CURR_FOLD_CODE
        && target_cell_flow == $past(target_cell_flow))
        else $error("foldback did not force the trickle target");

    a_fold_hold: assert property (foldback_active && !batt_recovered |=> foldback_active)
        else $error("foldback dropped between thresholds");

    a_enable_min: assert property (target_cell_flow <= chgsp_pkg::CURR_EN_MIN
        && !commit_cur |=> !charge_enable)
        else $error("charging enabled with low current word");

    a_timeout_stop: assert property ($rose(timed_out) |=> !charge_enable)
        else $error("charging survived the watchdog");

    a_reset_off: assert property (!volt_written || !cur_written |-> ##1 !charge_enable)
        else $error("charging before both registers written");

    a_curr_clamp: assert property (target_cell_flow[15:chgsp_pkg::CURR_MSB_POS + 1]
        != 3'h0 && !foldback_active
        && !commit_cur |=> dac.current_dac_bits == chgsp_pkg::CURR_CODE_MAX)
        else $error("over-range current not clamped");

endmodule : chgsp_top

// File: chgsp_pkg.sv
//
// Contract
// - Voltage word drops bits three to zero
// - Voltage request above 19.200V clamps there
// - Voltage below 1.024V gives zero, stops
// - Reset clears both; charger off until written
// - Voltage word in mV, bit 15 ignored
// - Voltage bits 4..14 weigh 16..16384 mV
// - Address 0x15 selects voltage set-point register
// - Reads return last stored word
// - Current word drops bits six to zero
// - Current request above 8.064A clamps there
// - Current below 128mA gives zero target
// - Current bits 7..12 weigh 128..4096 mA
// - Address 0x14 selects current set-point register
// - Battery low forces 128mA, word kept
// - Words move low byte first, high second
// - No set-point write in 175s ends charging
// - Enable needs current >0x007F, voltage >0x000F
//
package chgsp_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CURRENT = 8'h14;
    localparam logic [7:0] ADDR_VOLTAGE = 8'h15;
    localparam logic [15:0] RESET_CURRENT = 16'h0000;
    localparam logic [15:0] RESET_VOLTAGE = 16'h0000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // Field layout and limits
    // ------------------------------------------------------------
    localparam int VOLT_LSB_POS = 4;
    localparam int VOLT_MSB_POS = 14;
    localparam int CURR_LSB_POS = 7;
    localparam int CURR_MSB_POS = 12;
    localparam int VOLT_STEP_MV = 16;
    localparam int VOLT_MAX_MV = 19200;
    localparam int VOLT_MIN_MV = 1024;
    localparam logic [10:0] VOLT_CODE_MAX = 11'(VOLT_MAX_MV / VOLT_STEP_MV);
    localparam logic [10:0] VOLT_CODE_MIN = 11'(VOLT_MIN_MV / VOLT_STEP_MV);
    localparam logic [5:0] CURR_CODE_MAX = 6'h3f;
    localparam logic [5:0] CURR_FOLD_CODE = 6'h01;
    localparam logic [15:0] CURR_EN_MIN = 16'h007f;
    localparam logic [15:0] VOLT_EN_MIN = 16'h000f;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned TIMEOUT_S = 175;
    localparam longint unsigned TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [10:0] voltage_dac_bits;
        logic [5:0] current_dac_bits;
    } chgsp_dac_t;

endpackage : chgsp_pkg

// File: chgsp_volt_decode.sv
module chgsp_volt_decode (
    input wire logic [15:0] target_cell_potential,
    output logic [10:0] voltage_dac_bits
);

    // ------------------------------------------------------------
    // Word to DAC code
    // ------------------------------------------------------------
    function automatic logic [10:0] chgsp_volt_code(input logic [15:0] word);
        logic [10:0] raw;
        raw = word[chgsp_pkg::VOLT_MSB_POS:chgsp_pkg::VOLT_LSB_POS];
        if (raw > chgsp_pkg::VOLT_CODE_MAX)
            return chgsp_pkg::VOLT_CODE_MAX;
        else if (raw < chgsp_pkg::VOLT_CODE_MIN)
            return 11'h000;
        else
            return raw;
    endfunction : chgsp_volt_code

    assign voltage_dac_bits = chgsp_volt_code(target_cell_potential);

endmodule : chgsp_volt_decode

// File: chgsp_curr_decode.sv
module chgsp_curr_decode (
    input wire logic [15:0] target_cell_flow,
    input wire logic foldback,
    output logic [5:0] current_dac_bits
);

    // ------------------------------------------------------------
    // Word to DAC code
    // ------------------------------------------------------------
    function automatic logic [5:0] chgsp_curr_code(input logic [15:0] word);
        // Bits above the field still request more than full scale
        if (word[15:chgsp_pkg::CURR_MSB_POS + 1] != 3'h0)
            return chgsp_pkg::CURR_CODE_MAX;
        else
            return word[chgsp_pkg::CURR_MSB_POS:chgsp_pkg::CURR_LSB_POS];
    endfunction : chgsp_curr_code

    // Foldback overrides the target only; the stored word is untouched
    assign current_dac_bits = foldback ? chgsp_pkg::CURR_FOLD_CODE
                                       : chgsp_curr_code(target_cell_flow);

endmodule : chgsp_curr_decode

// File: chgsp_host_model.sv
module chgsp_host_model (
    input wire logic clk,
    output logic host_addr_valid,
    output logic [7:0] host_addr,
    output logic host_wr_valid,
    output logic [7:0] host_wr_byte,
    output logic host_stop,
    output logic host_rd_req,
    input wire logic host_rd_valid,
    input wire logic [7:0] host_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        host_addr_valid = 1'b0;
        host_addr = 8'h00;
        host_wr_valid = 1'b0;
        host_wr_byte = 8'h00;
        host_stop = 1'b0;
        host_rd_req = 1'b0;
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // Address, then nbytes data bytes, then stop; the address line inverts on each data byte, the byte line inverts at stop
    task automatic put_word(input logic [7:0] addr, input int nbytes, input logic [15:0] word);
        step();
        host_addr_valid = 1'b1;
        host_addr = addr;
        for (int i = 0; i < nbytes; i++)
        begin
            step();
            host_addr_valid = 1'b0;
            host_addr = ~host_addr;
            host_wr_valid = 1'b1;
            host_wr_byte = word[i*8 +: 8];
        end
        step();
        host_addr_valid = 1'b0;
        host_wr_valid = 1'b0;
        host_wr_byte = ~host_wr_byte;
        host_stop = 1'b1;
        step();
        host_stop = 1'b0;
    endtask : put_word

    // Select the register, then two back-to-back byte requests
    task automatic get_word(input logic [7:0] addr, output logic [15:0] word);
        put_word(addr, 0, 16'h0000);
        host_rd_req = 1'b1;
        step();
        word[7:0] = (host_rd_valid === 1'b1) ? host_rd_data : 8'hxx;
        step();
        word[15:8] = (host_rd_valid === 1'b1) ? host_rd_data : 8'hxx;
        host_rd_req = 1'b0;
    endtask : get_word
endmodule : chgsp_host_model

// File: tb_chgsp_top.sv
module tb_chgsp_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint unsigned TO_CYC = 200;

    logic clk;
    logic reset_n;
    logic host_addr_valid;
    logic [7:0] host_addr;
    logic host_wr_valid;
    logic [7:0] host_wr_byte;
    logic host_stop;
    logic host_rd_req;
    logic host_rd_valid;
    logic [7:0] host_rd_data;
    logic batt_low;
    logic batt_recovered;
    chgsp_pkg::chgsp_dac_t dac;
    logic charge_enable;
    logic foldback_active;
    logic timed_out;
    int bad_count;
    int compares;
    logic [15:0] rd;

    chgsp_top #(.TIMEOUT_CYCLES(TO_CYC)) uut (.clk(clk), .reset_n(reset_n),
        .host_addr_valid(host_addr_valid), .host_addr(host_addr),
        .host_wr_valid(host_wr_valid), .host_wr_byte(host_wr_byte), .host_stop(host_stop),
        .host_rd_req(host_rd_req), .host_rd_valid(host_rd_valid),
        .host_rd_data(host_rd_data), .batt_low(batt_low), .batt_recovered(batt_recovered),
        .dac(dac), .charge_enable(charge_enable), .foldback_active(foldback_active),
        .timed_out(timed_out));

    chgsp_host_model host (.clk(clk), .host_addr_valid(host_addr_valid),
        .host_addr(host_addr), .host_wr_valid(host_wr_valid), .host_wr_byte(host_wr_byte),
        .host_stop(host_stop), .host_rd_req(host_rd_req), .host_rd_valid(host_rd_valid),
        .host_rd_data(host_rd_data));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // ------------------------------------------------------------
    // Expected decoding
    // ------------------------------------------------------------
    function automatic logic [10:0] vcode(input logic [15:0] w);
        if (w[14:4] > 11'h4b0)
            return 11'h4b0;
        if (w[14:4] < 11'h040)
            return 11'h000;
        return w[14:4];
    endfunction : vcode

    function automatic logic [5:0] ccode(input logic [15:0] w);
        return (w[15:13] != 3'h0) ? 6'h3f : w[12:7];
    endfunction : ccode

    function automatic logic en(input logic [15:0] c, input logic [15:0] v);
        return (c > 16'h007f) && (v > 16'h000f) && (vcode(v) != 11'h000);
    endfunction : en

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        host.get_word(8'h14, rd);
        chk("current word", 16'h0000, rd);
        host.get_word(8'h15, rd);
        chk("voltage word", 16'h0000, rd);
        chk("voltage code", 16'h0000, {5'h00, dac.voltage_dac_bits});
        chk("current code", 16'h0000, {10'h000, dac.current_dac_bits});
        chk("enable", 16'h0000, {15'h0000, charge_enable});
        host.put_word(8'h15, 2, 16'h41a0);
        settle(1);
        chk("enable one written", 16'h0000, {15'h0000, charge_enable});
        $display("test reset done");
    endtask : t_reset

    task automatic t_volt();
        logic [15:0] tab [8] = '{16'h41a0, 16'hffff, 16'h03ff, 16'h0400, 16'h8400,
            16'h4b00, 16'h4b10, 16'h000f};
        host.put_word(8'h14, 2, 16'h0080);
        foreach (tab[i])
        begin
            host.put_word(8'h15, 2, tab[i]);
            settle(1);
            chk("voltage code", {5'h00, vcode(tab[i])}, {5'h00, dac.voltage_dac_bits});
            chk("enable", {15'h0000, en(16'h0080, tab[i])}, {15'h0000, charge_enable});
            host.get_word(8'h15, rd);
            chk("voltage word", tab[i], rd);
        end
        $display("test voltage done");
    endtask : t_volt

    task automatic t_curr();
        logic [15:0] tab [7] = '{16'h0080, 16'h1f80, 16'h007f, 16'hffff, 16'h2000,
            16'h0d55, 16'h0000};
        host.put_word(8'h15, 2, 16'h41a0);
        foreach (tab[i])
        begin
            host.put_word(8'h14, 2, tab[i]);
            settle(1);
            chk("current code", {10'h000, ccode(tab[i])}, {10'h000, dac.current_dac_bits});
            chk("enable", {15'h0000, en(tab[i], 16'h41a0)}, {15'h0000, charge_enable});
            host.get_word(8'h14, rd);
            chk("current word", tab[i], rd);
        end
        $display("test current done");
    endtask : t_curr

    task automatic t_refuse();
        host.put_word(8'h14, 2, 16'h1f80);
        host.put_word(8'h14, 1, 16'h0000);
        host.get_word(8'h14, rd);
        chk("short write kept", 16'h1f80, rd);
        host.put_word(8'h3f, 2, 16'h1234);
        host.get_word(8'h3f, rd);
        chk("unmapped read", 16'h0000, rd);
        host.get_word(8'h14, rd);
        chk("current after unmapped", 16'h1f80, rd);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_fold();
        host.put_word(8'h14, 2, 16'h0f80);
        batt_low = 1'b1;
        settle(2);
        chk("foldback on", 16'h0001, {15'h0000, foldback_active});
        chk("forced code", 16'h0001, {10'h000, dac.current_dac_bits});
        chk("enable", 16'h0001, {15'h0000, charge_enable});
        batt_low = 1'b0;
        host.get_word(8'h14, rd);
        chk("word kept", 16'h0f80, rd);
        chk("foldback held", 16'h0001, {15'h0000, foldback_active});
        batt_recovered = 1'b1;
        settle(2);
        chk("foldback off", 16'h0000, {15'h0000, foldback_active});
        chk("restored code", 16'h001f, {10'h000, dac.current_dac_bits});
        batt_low = 1'b1;
        settle(1);
        chk("low wins", 16'h0001, {15'h0000, foldback_active});
        batt_low = 1'b0;
        settle(1);
        chk("foldback cleared", 16'h0000, {15'h0000, foldback_active});
        batt_recovered = 1'b0;
        $display("test foldback done");
    endtask : t_fold

    task automatic t_timeout();
        host.put_word(8'h15, 2, 16'h41a0);
        settle(int'(TO_CYC) + 3);
        chk("timed out", 16'h0001, {15'h0000, timed_out});
        chk("enable", 16'h0000, {15'h0000, charge_enable});
        host.put_word(8'h14, 2, 16'h0f80);
        settle(1);
        chk("rearmed", 16'h0000, {15'h0000, timed_out});
        chk("enable", 16'h0001, {15'h0000, charge_enable});
        $display("test timeout done");
    endtask : t_timeout

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        bad_count = 0;
        compares = 0;
        reset_n = 1'b0;
        batt_low = 1'b0;
        batt_recovered = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_volt();
        t_curr();
        t_refuse();
        t_fold();
        t_timeout();
        report_and_stop();
    end
endmodule : tb_chgsp_top
